// File: hw/core_sfr_pointer_bank.sv
// core register bank: stack pointer, data pointer and core registers
`timescale 1ns/10ps
module core_sfr_pointer_bank (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire core_sfr_pkg::sfr_req_s req_i,
  input wire core_sfr_pkg::stack_op_s stack_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic hit_o,
  output logic mem_we_o,
  output logic [7:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic [15:0] data_ptr_o,
  output logic [7:0] stack_top_o
);
  logic [7:0] regs_r [core_sfr_pkg::NUM_REGS];
  logic [7:0] regs_nxt [core_sfr_pkg::NUM_REGS];
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic mem_we_r, mem_we_nxt;
  logic [7:0] mem_addr_r, mem_addr_nxt;
  logic [7:0] mem_wdata_r, mem_wdata_nxt;
  logic dec_hit, dec_bit_ok;
  core_sfr_pkg::reg_idx_t dec_idx;
  logic [7:0] cur, bit_merged, pushed_top;

  localparam core_sfr_pkg::reg_idx_t IDX_STACK = 3'h0;
  localparam core_sfr_pkg::reg_idx_t IDX_LOW = 3'h1;
  localparam core_sfr_pkg::reg_idx_t IDX_HIGH = 3'h2;

  sfr_addr_decode u_decode (
    .req_i(req_i),
    .hit_o(dec_hit),
    .bit_ok_o(dec_bit_ok),
    .idx_o(dec_idx)
  );

  // next register values; a push and a software write to the pointer in the
  // same cycle is not expected, the push wins since it comes from the core
  always_comb begin
    for (int i = 0; i < core_sfr_pkg::NUM_REGS; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    cur = regs_r[dec_idx];
    bit_merged = cur;
    bit_merged[req_i.bit_pos] = req_i.wdata[0];
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (req_i.wr && dec_hit) begin
      // bit writes only land on bit-capable registers, others ignore them
      if (!req_i.bit_mode) begin
        regs_nxt[dec_idx] = req_i.wdata;
      end else if (dec_bit_ok) begin
        regs_nxt[dec_idx] = bit_merged;
      end
    end
    if (req_i.rd) begin
      rvalid_nxt = 1'b1;
      // unmapped or indirect reads return zero rather than stale data
      if (!dec_hit) begin
        rdata_nxt = core_sfr_pkg::UNMAPPED_READ;
      end else if (req_i.bit_mode) begin
        rdata_nxt = dec_bit_ok ? {7'h00, cur[req_i.bit_pos]} : core_sfr_pkg::UNMAPPED_READ;
      end else begin
        rdata_nxt = cur;
      end
    end
    pushed_top = regs_r[IDX_STACK] + core_sfr_pkg::STACK_STEP;
    if (stack_i.push) begin
      regs_nxt[IDX_STACK] = pushed_top;
    end else if (stack_i.pop) begin
      regs_nxt[IDX_STACK] = regs_r[IDX_STACK] - core_sfr_pkg::STACK_STEP;
    end
  end

  // memory write port for pushes: byte goes to the incremented location
  always_comb begin
    mem_we_nxt = stack_i.push;
    mem_addr_nxt = stack_i.push ? pushed_top : mem_addr_r;
    mem_wdata_nxt = stack_i.push ? stack_i.data : mem_wdata_r;
  end

  // register stage; reserved and unused bits all clear on reset
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      regs_r[IDX_STACK] <= core_sfr_pkg::RST_STACK_TOP;
      regs_r[IDX_LOW] <= core_sfr_pkg::RST_PTR_LOW;
      regs_r[IDX_HIGH] <= core_sfr_pkg::RST_PTR_HIGH;
      regs_r[3] <= core_sfr_pkg::RST_STATUS_WORD;
      regs_r[4] <= core_sfr_pkg::RST_ACCUMULATOR;
      regs_r[5] <= core_sfr_pkg::RST_AUX_OPERAND;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= 8'h00;
      mem_wdata_r <= 8'h00;
    end else if (clk_en_i) begin
      for (int i = 0; i < core_sfr_pkg::NUM_REGS; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      mem_we_r <= mem_we_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign hit_o = dec_hit;
  assign mem_we_o = mem_we_r;
  assign mem_addr_o = mem_addr_r;
  assign mem_wdata_o = mem_wdata_r;
  assign stack_top_o = regs_r[IDX_STACK];
  // indirect data memory address, high byte on top
  assign data_ptr_o = {regs_r[IDX_HIGH], regs_r[IDX_LOW]};

  // reset value of the stack pointer shows one cycle after reset
  chk_stack_reset: assert property (@(posedge clock_i)
    sys_rst_i |=> stack_top_o == core_sfr_pkg::RST_STACK_TOP)
    else $error("stack pointer not reset to its default");

  sequence push_taken;
    clk_en_i && stack_i.push;
  endsequence

  chk_push_increment: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    push_taken |=> stack_top_o == $past(stack_top_o) + core_sfr_pkg::STACK_STEP)
    else $error("push did not increment stack pointer");

  chk_push_location: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    push_taken |=> mem_we_o && mem_addr_o == stack_top_o)
    else $error("pushed byte not stored at new top");

  chk_pointer_join: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    clk_en_i && req_i.wr && !req_i.bit_mode && req_i.direct
      && req_i.addr == core_sfr_pkg::ADDR_PTR_HIGH
      |=> data_ptr_o[15:8] == $past(req_i.wdata))
    else $error("high byte write missing from data pointer");

  chk_low_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    clk_en_i && req_i.wr && !req_i.bit_mode && req_i.direct
      && req_i.addr == core_sfr_pkg::ADDR_PTR_LOW
      |=> data_ptr_o[7:0] == $past(req_i.wdata))
    else $error("low byte write missing from data pointer");

  chk_indirect_miss: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !req_i.direct |-> !hit_o)
    else $error("indirect access reached the register bank");

  chk_stack_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    clk_en_i && req_i.wr && !req_i.bit_mode && req_i.direct && !stack_i.push
      && !stack_i.pop && req_i.addr == core_sfr_pkg::ADDR_STACK_TOP
      |=> stack_top_o == $past(req_i.wdata))
    else $error("stack pointer write lost");

  chk_read_back: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    clk_en_i && req_i.rd && !req_i.bit_mode && req_i.direct
      && req_i.addr == core_sfr_pkg::ADDR_PTR_HIGH
      |=> rvalid_o && rdata_o == data_ptr_o[15:8])
    else $error("high byte read returned wrong value");

  chk_bit_refused: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    clk_en_i && req_i.wr && req_i.bit_mode && req_i.direct && !stack_i.push
      && !stack_i.pop && req_i.addr == core_sfr_pkg::ADDR_STACK_TOP
      |=> $stable(stack_top_o))
    else $error("bit write altered a byte-only register");

  // answers and side effects beyond the basic write paths
  sequence pop_taken;
    clk_en_i && stack_i.pop && !stack_i.push;
  endsequence

  sequence stack_read_taken;
    clk_en_i && req_i.rd && !req_i.wr && !req_i.bit_mode && req_i.direct
      && req_i.addr == core_sfr_pkg::ADDR_STACK_TOP && !stack_i.push && !stack_i.pop;
  endsequence

  // popping is a local choice: the pointer steps back by one
  chk_pop_decrement: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    pop_taken |=> stack_top_o == $past(stack_top_o) - core_sfr_pkg::STACK_STEP)
    else $error("pop did not decrement stack pointer");

  chk_push_data: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    push_taken |=> mem_wdata_o == $past(stack_i.data))
    else $error("pushed byte not presented on memory port");

  // the memory write strobe is a single-cycle pulse per push
  chk_push_pulse: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    clk_en_i && !stack_i.push |=> !mem_we_o)
    else $error("memory write strobe outlived its push");

  chk_stack_read: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    stack_read_taken |=> rvalid_o && rdata_o == stack_top_o)
    else $error("stack pointer read returned wrong value");

  chk_low_read: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    clk_en_i && req_i.rd && !req_i.wr && !req_i.bit_mode && req_i.direct
      && req_i.addr == core_sfr_pkg::ADDR_PTR_LOW
      |=> rvalid_o && rdata_o == data_ptr_o[7:0])
    else $error("low byte read returned wrong value");

  // a reset also returns the whole data pointer to its defaults
  chk_pointer_reset: assert property (@(posedge clock_i)
    sys_rst_i |=> data_ptr_o == {core_sfr_pkg::RST_PTR_HIGH, core_sfr_pkg::RST_PTR_LOW})
    else $error("data pointer not reset to its default");

  // reads that miss the bank still answer, with the fixed fill value
  chk_unmapped_read: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    clk_en_i && req_i.rd && !hit_o |=> rvalid_o && rdata_o == core_sfr_pkg::UNMAPPED_READ)
    else $error("missed read did not return the fill value");

  chk_bit_read_zero: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    clk_en_i && req_i.rd && req_i.bit_mode && hit_o
      && (req_i.addr[2:0] & core_sfr_pkg::BIT_ADDR_LOW_MASK) != 3'h0
      |=> rdata_o == core_sfr_pkg::UNMAPPED_READ)
    else $error("bit read of a byte-only register returned data");

  // a low enable must freeze every visible register
  chk_enable_freeze: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !clk_en_i |=> $stable(data_ptr_o) && $stable(stack_top_o) && $stable(rdata_o)
      && $stable(rvalid_o) && $stable(mem_we_o))
    else $error("state moved while the clock enable was low");

  chk_rvalid_pulse: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    clk_en_i && !req_i.rd |=> !rvalid_o)
    else $error("read valid outlived its read");
endmodule

// File: common/core_sfr_pkg.sv
// constants and carrier types for the core register bank
// Notes on behaviour
// - stack_top_pointer is an 8-bit read/write register at direct address 0x81.
// - a push increments stack_top_pointer first, then writes the byte there.
// - stack_top_pointer loads 0x07 on every reset.
// - pointer_low_byte is read/write and holds the data pointer's low byte.
// - the 16-bit data pointer addresses indirect data memory accesses.
// - address 0x83 selects pointer_high_byte, address 0x82 selects pointer_low_byte.
// - every reserved bit resets to zero.
// - only direct accesses in 0x80..0xff reach these registers, indirect ones go to memory.
// - registers at addresses ending in 0 or 8 also allow single-bit access.
package core_sfr_pkg;
  localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
  localparam logic [7:0] ADDR_PTR_LOW = 8'h82;
  localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'hd0;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'he0;
  localparam logic [7:0] ADDR_AUX_OPERAND = 8'hf0;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_PTR_LOW = 8'h07;
  localparam logic [7:0] RST_PTR_HIGH = 8'h00;
  localparam logic [7:0] RST_STATUS_WORD = 8'h00;
  localparam logic [7:0] RST_ACCUMULATOR = 8'h00;
  localparam logic [7:0] RST_AUX_OPERAND = 8'h00;
  localparam logic [7:0] STACK_STEP = 8'h01;
  localparam logic [2:0] BIT_ADDR_LOW_MASK = 3'h7;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int NUM_REGS = 6;

  typedef logic [2:0] reg_idx_t;

  // one access from the core: byte or bit, direct or indirect
  typedef struct packed {
    logic rd;
    logic wr;
    logic direct;
    logic bit_mode;
    logic [7:0] addr;
    logic [2:0] bit_pos;
    logic [7:0] wdata;
  } sfr_req_s;

  // one stack operation from the core
  typedef struct packed {
    logic push;
    logic pop;
    logic [7:0] data;
  } stack_op_s;
endpackage

// File: hw/sfr_addr_decode.sv
// address decoder for the core register bank
`timescale 1ns/10ps
module sfr_addr_decode (
  input wire core_sfr_pkg::sfr_req_s req_i,
  output logic hit_o,
  output logic bit_ok_o,
  output core_sfr_pkg::reg_idx_t idx_o
);
  logic in_space;

  // only direct accesses in the upper half reach the bank
  always_comb begin
    in_space = req_i.direct && (req_i.addr >= core_sfr_pkg::SFR_BASE);
    hit_o = 1'b0;
    idx_o = '0;
    unique case (req_i.addr)
      core_sfr_pkg::ADDR_STACK_TOP: begin
        hit_o = in_space;
        idx_o = 3'h0;
      end
      core_sfr_pkg::ADDR_PTR_LOW: begin
        hit_o = in_space;
        idx_o = 3'h1;
      end
      core_sfr_pkg::ADDR_PTR_HIGH: begin
        hit_o = in_space;
        idx_o = 3'h2;
      end
      core_sfr_pkg::ADDR_STATUS_WORD: begin
        hit_o = in_space;
        idx_o = 3'h3;
      end
      core_sfr_pkg::ADDR_ACCUMULATOR: begin
        hit_o = in_space;
        idx_o = 3'h4;
      end
      core_sfr_pkg::ADDR_AUX_OPERAND: begin
        hit_o = in_space;
        idx_o = 3'h5;
      end
      default: begin
        hit_o = 1'b0;
        idx_o = '0;
      end
    endcase
    // low nibble 0 or 8 means the register takes single-bit access
    bit_ok_o = ((req_i.addr[2:0] & core_sfr_pkg::BIT_ADDR_LOW_MASK) == 3'h0);
  end
endmodule

// File: testbench/core_access_model.sv
// processor-core stand-in that issues register and stack requests
`timescale 1ns/10ps
module core_access_model (
  input wire logic clock_i,
  output core_sfr_pkg::sfr_req_s req_o,
  output core_sfr_pkg::stack_op_s stack_o
);
  initial begin
    req_o = '0;
    stack_o = '0;
  end
  // one request per call, launched and released at falling edges
  // released requests clear rd and wr and invert the other fields so a stale address never looks live
  task automatic access(input logic rd, wr, dir, bm, input logic [7:0] a,
                        input logic [2:0] p, input logic [7:0] d);
    @(negedge clock_i);
    req_o = '{rd, wr, dir, bm, a, p, d};
    @(negedge clock_i);
    req_o = '{1'b0, 1'b0, ~dir, ~bm, ~a, ~p, ~d};
  endtask
  // stack request held for exactly one rising edge
  task automatic stack_op(input logic pu, po, input logic [7:0] d);
    @(negedge clock_i);
    stack_o = '{pu, po, d};
    @(negedge clock_i);
    stack_o = '{1'b0, 1'b0, ~d};
  endtask
endmodule

// File: testbench/core_sfr_pointer_bank_tb_top.sv
// self-checking bench for the core register bank
`timescale 1ns/10ps
module core_sfr_pointer_bank_tb_top;
  logic clock_i, sys_rst_i, clk_en_i, rvalid, hit, mem_we;
  core_sfr_pkg::sfr_req_s req;
  core_sfr_pkg::stack_op_s stk;
  logic [7:0] rdata, mem_addr, mem_wdata, stack_top, v;
  logic [15:0] data_ptr;
  logic [7:0] mdl [256];
  logic [7:0] regs [6] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0};
  int mismatches = 0, num_checks = 0, seed = 56355;

  core_sfr_pointer_bank u_core_sfr_pointer_bank (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i), .req_i(req), .stack_i(stk), .rdata_o(rdata), .rvalid_o(rvalid),
    .hit_o(hit), .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
    .data_ptr_o(data_ptr), .stack_top_o(stack_top));
  core_access_model u_core_access_model (.clock_i(clock_i), .req_o(req), .stack_o(stk));

  // bank membership from the register list, never from the decoder
  function automatic logic is_bank(input logic [7:0] a);
    logic f;
    f = 1'b0;
    foreach (regs[i]) if (regs[i] == a) f = 1'b1;
    return f;
  endfunction

  // decoder hit must follow every live request while it stands
  always @(posedge clock_i) begin
    if (!sys_rst_i && (req.rd || req.wr)) begin
      chk("hit", {15'h0, req.direct && is_bank(req.addr)}, {15'h0, hit});
    end
  end

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // reset held four cycles; model returns to the documented defaults
  task automatic do_reset();
    @(negedge clock_i);
    sys_rst_i = 1'b1;
    repeat (4) @(negedge clock_i);
    sys_rst_i = 1'b0;
    mdl = '{default: 8'h00};
    mdl[8'h81] = 8'h07;
    mdl[8'h82] = 8'h07;
    chk("stack_top", 16'h0007, {8'h00, stack_top});
    chk("data_ptr", 16'h0007, data_ptr);
  endtask

  // register access with model update and bounded wait for read data
  task automatic xfer(input logic rd, wr, dir, bm, input logic [7:0] a,
                      input logic [2:0] p, input logic [7:0] d);
    logic [7:0] e;
    e = !dir ? 8'h00 : bm ? {7'h00, (a[2:0] == 3'h0) & mdl[a][p]} : mdl[a];
    u_core_access_model.access(rd, wr, dir, bm, a, p, d);
    if (wr && dir && is_bank(a) && (!bm || a[2:0] == 3'h0)) begin
      if (bm) mdl[a][p] = d[0];
      else mdl[a] = d;
    end
    if (rd) begin
      for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clock_i);
      if (rvalid !== 1'b1) begin
        mismatches++;
        complete_run();
      end
      chk("rdata", {8'h00, e}, {8'h00, rdata});
      // read valid is a one-cycle pulse
      @(negedge clock_i);
      chk("rvalid", 16'h0, {15'h0, rvalid});
    end
  endtask

  // push: pointer moves up first, byte lands at the new top
  task automatic push_chk(input logic [7:0] d);
    mdl[8'h81] = mdl[8'h81] + 8'h01;
    u_core_access_model.stack_op(1'b1, 1'b0, d);
    chk("mem_we", 16'h1, {15'h0, mem_we});
    chk("mem_addr", {8'h00, mdl[8'h81]}, {8'h00, mem_addr});
    chk("mem_wdata", {8'h00, d}, {8'h00, mem_wdata});
    chk("stack_top", {8'h00, mdl[8'h81]}, {8'h00, stack_top});
    @(negedge clock_i);
    chk("mem_we", 16'h0, {15'h0, mem_we});
  endtask

  initial begin
    sys_rst_i = 1'b1;
    clk_en_i = 1'b1;
    do_reset();
    foreach (regs[i]) xfer(1, 0, 1, 0, regs[i], 3'h0, 8'h00);
    repeat (2) begin
      foreach (regs[i]) xfer(0, 1, 1, 0, regs[i], 3'h0, 8'($random(seed)));
      foreach (regs[i]) xfer(1, 0, 1, 0, regs[i], 3'h0, 8'h00);
      chk("data_ptr", {mdl[8'h83], mdl[8'h82]}, data_ptr);
    end
    // indirect and foreign places: writes dropped, reads give zero; the foreign
    // address belongs to another block, unoccupied addresses are left alone
    xfer(0, 1, 0, 0, 8'h83, 3'h0, 8'h5a);
    xfer(0, 1, 1, 0, 8'h87, 3'h0, 8'h5a);
    xfer(1, 0, 0, 0, 8'h83, 3'h0, 8'h00);
    xfer(1, 0, 1, 0, 8'h87, 3'h0, 8'h00);
    xfer(1, 0, 1, 0, 8'h83, 3'h0, 8'h00);
    for (int p = 0; p < 8; p++) begin
      xfer(0, 1, 1, 1, 8'he0, 3'(p), 8'($random(seed)));
      xfer(0, 1, 1, 1, 8'h83, 3'(p), 8'hff);
      xfer(1, 0, 1, 1, 8'he0, 3'(p), 8'h00);
      xfer(1, 0, 1, 1, 8'h83, 3'(p), 8'h00);
    end
    xfer(1, 0, 1, 0, 8'he0, 3'h0, 8'h00);
    xfer(1, 0, 1, 0, 8'h83, 3'h0, 8'h00);
    // wrap of the pointer at the top of memory
    xfer(0, 1, 1, 0, 8'h81, 3'h0, 8'hfe);
    push_chk(8'($random(seed)));
    push_chk(8'hc3);
    u_core_access_model.stack_op(1'b0, 1'b1, 8'h00);
    mdl[8'h81] = mdl[8'h81] - 8'h01;
    chk("stack_top", {8'h00, mdl[8'h81]}, {8'h00, stack_top});
    // disabled clock: write must leave the register untouched
    v = 8'($random(seed));
    clk_en_i = 1'b0;
    u_core_access_model.access(1'b0, 1'b1, 1'b1, 1'b0, 8'he0, 3'h0, ~mdl[8'he0]);
    clk_en_i = 1'b1;
    xfer(1, 0, 1, 0, 8'he0, 3'h0, 8'h00);
    do_reset();
    xfer(1, 0, 1, 0, 8'hd0, 3'h0, v);
    complete_run();
  end
endmodule
